//--- dv/kwic_checker.sv
// Checker for kwic_top: bus answer, reset state, sticky requests, irq
// Assumes a bind to kwic_top; sees its ports only
`timescale 1ns/1ps
`default_nettype none
module kwic_checker (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic [1:0] key_pin,
	input wire logic [1:0] key_pullup_en,
	input wire logic [1:0] key_wake_req,
	input wire logic irq
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	logic [1:0] clr;
	// Status clear lands at the ack edge only
	assign clr = (wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i[7:2] == 6'h02) ? wb_dat_i[1:0] : 2'h0;
	sequence s_take; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
	sequence s_pulse; wb_ack_o ##1 !wb_ack_o; endsequence
	property p_ack; s_take |=> s_pulse; endproperty
	a_ack: assert property (p_ack) else $error("bad ack timing");
	property p_cause; wb_ack_o |-> $past(wb_cyc_i && wb_stb_i); endproperty
	a_cause: assert property (p_cause) else $error("ack without request");
	property p_rst; disable iff (1'b0) sys_rst |=> key_wake_req == 2'h0 && !irq && key_pullup_en == 2'h3; endproperty
	a_rst: assert property (p_rst) else $error("bad reset state");
	property p_upper; wb_ack_o |-> wb_dat_o[31:8] == 24'h0; endproperty
	a_upper: assert property (p_upper) else $error("upper read bits set");
	property p_unmap; wb_ack_o && !wb_we_i && wb_adr_i > 8'h13 |-> wb_dat_o == 32'h0; endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
	property p_irq; irq |-> key_wake_req != 2'h0; endproperty
	a_irq: assert property (p_irq) else $error("irq without request");
	property p_hold0; key_wake_req[0] && !clr[0] |=> key_wake_req[0]; endproperty
	a_hold0: assert property (p_hold0) else $error("request 0 lost");
	property p_hold1; key_wake_req[1] && !clr[1] |=> key_wake_req[1]; endproperty
	a_hold1: assert property (p_hold1) else $error("request 1 lost");
endmodule // kwic_checker
`default_nettype wire

//--- dv/kwic_keys.sv
// Key switch model: a press pulls the pin low, else pull-up or float
// Assumes pull-up enables come from the block; a floating pin wanders
`timescale 1ns/1ps
`default_nettype none
module kwic_keys (
	input wire logic clk,
	input wire logic [1:0] press,
	input wire logic [1:0] pullup_en,
	output logic [1:0] pin
);
	logic [1:0] float_q = 2'h0;
	// Undriven pin toggles so a stale level never looks valid
	always @(posedge clk) float_q <= ~pin;
	assign pin = ~press & (pullup_en | float_q);
endmodule // kwic_keys
`default_nettype wire

//--- dv/tb_top.sv
// Testbench for kwic_top: registers, triggers, enable, irq, pull-up modes
// Assumes kwic_checker.sv and kwic_keys.sv compiled first
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [31:0] dat = 32'h0;
	logic [3:0] sel = 4'h0;
	logic [31:0] rd;
	logic [31:0] dat_o;
	logic ack;
	logic irq;
	logic [1:0] press = 2'h0;
	logic [1:0] pin;
	logic [1:0] pu;
	logic [1:0] req;
	int miscompares = 0;
	int cmp_count = 0;
	int cycles = 0;
	// Short pull-up period keeps the run brief
	kwic_top #(.PU_PERIOD_CYC(8), .PU_ON_CYC(4)) kwic_top_i (.clk(clk), .sys_rst(sys_rst),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
		.wb_dat_o(dat_o), .wb_ack_o(ack), .key_pin(pin), .key_pullup_en(pu), .key_wake_req(req), .irq(irq));
	kwic_keys kwic_keys_i (.clk(clk), .press(press), .pullup_en(pu), .pin(pin));
	initial begin
		forever #2 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			miscompares++;
			end_of_test();
		end
	end
	////////////////////////////////////////////////////////////////
	task automatic end_of_test();
		$display("compares %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hf);
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		sel <= s;
		adr <= a;
		dat <= d;
		do @(posedge clk); while (ack !== 1'b1);
		rd = dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] e);
		wb(1'b0, a, 32'h0);
		chk(rd, e);
	endtask
	task automatic wait_n(input int k);
		repeat (k) @(posedge clk);
	endtask
	////////////////////////////////////////////////////////////////
	task automatic t_reset();
		rchk(8'h00, 32'h20);
		rchk(8'h04, 32'h20);
		rchk(8'h08, 32'h0);
		rchk(8'h0c, 32'h0);
		rchk(8'h10, 32'h33);
		rchk(8'h40, 32'h0);
		wb(1'b1, 8'h00, 32'hff, 4'he);
		rchk(8'h00, 32'h20);
		wb(1'b1, 8'h00, 32'hff);
		press[0] <= 1'b1;
		rchk(8'h00, 32'hf1);
		// Codes above both-edges stay silent even with the pin held low
		wait_n(12);
		chk(req, 2'h0);
		wb(1'b1, 8'h00, 32'h20);
		$display("test reset and fields done");
	endtask
	task automatic t_trig();
		logic [2:0] c;
		for (int ch = 0; ch < 2; ch++) begin
			for (int k = 0; k < 5; k++) begin
				c = k[2:0];
				press[ch] <= c[0];
				wait_n(4);
				wb(1'b1, 8'(ch * 4), {24'h0, 1'b0, c, 4'h1});
				wb(1'b1, 8'h08, 32'h3);
				wait_n(4);
				chk(req[ch], 1'b0);
				press[ch] <= ~c[0];
				wait_n(4);
				chk(req[ch], 1'b1);
				wb(1'b1, 8'h08, 32'h3);
				wait_n(4);
				chk(req[ch], c < 3'h2);
				press[ch] <= c[0];
				wait_n(4);
				chk(req[ch], c != 3'h2 && c != 3'h3);
				wb(1'b1, 8'(ch * 4), 32'h20);
			end
		end
		$display("test triggers done");
	endtask
	task automatic t_irq();
		wb(1'b1, 8'h08, 32'h3);
		press[0] <= 1'b1;
		wait_n(4);
		chk(req, 2'h0);
		press[0] <= 1'b0;
		wait_n(4);
		wb(1'b1, 8'h00, 32'h21);
		press[0] <= 1'b1;
		wait_n(4);
		chk({irq, req}, 3'h1);
		wb(1'b1, 8'h0c, 32'h1);
		wait_n(1);
		chk(irq, 1'b1);
		wb(1'b1, 8'h08, 32'h1);
		wait_n(1);
		chk({irq, req}, 3'h0);
		press[0] <= 1'b0;
		$display("test irq done");
	endtask
	task automatic t_pullup();
		logic [31:0] n;
		// Dynamic: on 4 of every 8 cycles; static: always on
		for (int m = 0; m < 2; m++) begin
			wb(1'b1, 8'h00, m ? 32'h20 : 32'ha0);
			wait_n(2);
			n = 32'h0;
			repeat (16) begin
				@(posedge clk);
				n = n + 32'(pu[0]);
			end
			chk(n, m ? 16 : 8);
			if (m == 0) begin
				// A press in dynamic mode is still caught at the next on window
				wb(1'b1, 8'h00, 32'ha1);
				press[0] <= 1'b1;
				wait_n(16);
				chk(req[0], 1'b1);
				wb(1'b1, 8'h08, 32'h1);
				press[0] <= 1'b0;
			end
		end
		$display("test pull-up done");
	endtask
	initial begin
		wait_n(10);
		sys_rst <= 1'b0;
		t_reset();
		t_trig();
		t_irq();
		t_pullup();
		end_of_test();
	end
endmodule // tb_top
bind kwic_top kwic_checker kwic_checker_i (.clk(clk), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
	.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .key_pin(key_pin), .key_pullup_en(key_pullup_en),
	.key_wake_req(key_wake_req), .irq(irq));
`default_nettype wire

//--- hw/kwic_cfg.svh
// Key wake-up input config: offsets, field positions, reset values, timing counts
// Assumes a 32-bit classic Wishbone bus with word-aligned registers
`ifndef KWIC_CFG_SVH
`define KWIC_CFG_SVH

`define KWIC_ADR_W 8
`define KWIC_OFS_CH6 8'h00
`define KWIC_OFS_CH7 8'h04
`define KWIC_OFS_STATUS 8'h08
`define KWIC_OFS_MASK 8'h0c
`define KWIC_OFS_PINS 8'h10

`define KWIC_BIT_PULLUP 7
`define KWIC_TRIG_MSB 6
`define KWIC_TRIG_LSB 4
`define KWIC_BIT_IRQ_EN 0
`define KWIC_CH_RESET 8'h20
`define KWIC_CH_WMASK 8'hf1
`define KWIC_PINS_PU_LSB 4

`define KWIC_TRIG_LOW 3'h0
`define KWIC_TRIG_HIGH 3'h1
`define KWIC_TRIG_FALL 3'h2
`define KWIC_TRIG_RISE 3'h3
`define KWIC_TRIG_BOTH 3'h4

`define KWIC_PU_PERIOD_CYC 256
`define KWIC_PU_ON_CYC 16

`endif

//--- hw/kwic_detect.sv
// Key wake-up input config: trigger condition detector for one key pin
// Assumes the pin is synchronous to clk; sample_en marks valid samples
`include "kwic_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module kwic_detect (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic key_pin,
	input wire logic sample_en,
	input wire logic [2:0] trig,
	output logic hit,
	output logic level
);
	logic level_q, level_d;
	logic hit_q, hit_d;

	function automatic logic trig_match(input logic [2:0] code, input logic now, input logic was);
		logic m;
		m = 1'b0;
		case (code)
			`KWIC_TRIG_LOW: m = !now;
			`KWIC_TRIG_HIGH: m = now;
			`KWIC_TRIG_FALL: m = was && !now;
			`KWIC_TRIG_RISE: m = !was && now;
			`KWIC_TRIG_BOTH: m = was != now;
			// Codes above both-edges never trigger
			default: m = 1'b0;
		endcase
		return m;
	endfunction

	always_comb begin
		level_d = level_q;
		hit_d = 1'b0;
		if (sample_en) begin
			level_d = key_pin;
			hit_d = trig_match(trig, key_pin, level_q);
		end
	end

	// Idle level high matches a pulled-up open key, so no edge at start
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			level_q <= 1'b1;
			hit_q <= 1'b0;
		end else begin
			level_q <= level_d;
			hit_q <= hit_d;
		end
	end

	assign hit = hit_q;
	assign level = level_q;

endmodule // kwic_detect

`default_nettype wire

//--- hw/kwic_pkg.sv
// Key wake-up input config: shared types
// Assumes kwic_cfg.svh supplies all numeric constants
package kwic_pkg;

	typedef struct packed {
		logic pullup_dyn;
		logic [2:0] trig;
		logic [2:0] rsvd;
		logic irq_en;
	} kwic_chan_cfg_type;

	typedef struct packed {
		logic cyc;
		logic stb;
		logic we;
		logic [7:0] adr;
		logic [3:0] sel;
		logic [31:0] dat;
	} kwic_wb_req_type;

	typedef enum logic [2:0] {
		KWIC_PU_STATIC = 3'h1,
		KWIC_PU_ON = 3'h2,
		KWIC_PU_OFF = 3'h4
	} kwic_pu_state_type;

endpackage

//--- hw/kwic_pullup.sv
// Key wake-up input config: per-pin pull-up sequencer, static or periodic
// Assumes the pin settles within the on window; sampling happens at its last cycle
`include "kwic_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module kwic_pullup #(
	parameter int PERIOD_CYC = `KWIC_PU_PERIOD_CYC,
	parameter int ON_CYC = `KWIC_PU_ON_CYC
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic pullup_dyn,
	output logic pullup_on,
	output logic sample_en
);
	kwic_pkg::kwic_pu_state_type state_q, state_d;
	logic [15:0] cnt_q, cnt_d;
	logic pu_q, pu_d;

	always_comb begin
		state_d = state_q;
		cnt_d = cnt_q;
		pu_d = pu_q;
		sample_en = 1'b0;
		unique case (state_q)
			kwic_pkg::KWIC_PU_STATIC: begin
				sample_en = 1'b1;
				pu_d = 1'b1;
				if (pullup_dyn) begin
					state_d = kwic_pkg::KWIC_PU_ON;
					cnt_d = 16'h0000;
				end
			end
			kwic_pkg::KWIC_PU_ON: begin
				cnt_d = cnt_q + 16'h0001;
				pu_d = 1'b1;
				// Sample only once the pull-up has had time to lift an open key
				if (cnt_q == 16'(ON_CYC - 1)) begin
					sample_en = 1'b1;
					state_d = kwic_pkg::KWIC_PU_OFF;
					pu_d = 1'b0;
				end
			end
			kwic_pkg::KWIC_PU_OFF: begin
				cnt_d = cnt_q + 16'h0001;
				if (cnt_q == 16'(PERIOD_CYC - 1)) begin
					state_d = kwic_pkg::KWIC_PU_ON;
					cnt_d = 16'h0000;
					pu_d = 1'b1;
				end
			end
		endcase
		if (!pullup_dyn) begin
			state_d = kwic_pkg::KWIC_PU_STATIC;
			pu_d = 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			state_q <= kwic_pkg::KWIC_PU_STATIC;
			cnt_q <= 16'h0000;
			pu_q <= 1'b1;
		end else begin
			state_q <= state_d;
			cnt_q <= cnt_d;
			pu_q <= pu_d;
		end
	end

	assign pullup_on = pu_q;

endmodule // kwic_pullup

`default_nettype wire

//--- hw/kwic_top.sv
// Key wake-up input config: two key channels with Wishbone registers and interrupt
// Assumes one clock, synchronous key pins and a classic Wishbone master
`include "kwic_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module kwic_top #(
	parameter int PU_PERIOD_CYC = `KWIC_PU_PERIOD_CYC,
	parameter int PU_ON_CYC = `KWIC_PU_ON_CYC
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic [1:0] key_pin,
	output logic [1:0] key_pullup_en,
	output logic [1:0] key_wake_req,
	output logic irq
);
	// Channel six is index 0, channel seven index 1
	localparam int NCH = 2;

	////////////////////////////////////////////////////////////////////////////
	// Bus request carrier

	kwic_pkg::kwic_wb_req_type req;

	assign req.cyc = wb_cyc_i;
	assign req.stb = wb_stb_i;
	assign req.we = wb_we_i;
	assign req.adr = wb_adr_i;
	assign req.sel = wb_sel_i;
	assign req.dat = wb_dat_i;

	////////////////////////////////////////////////////////////////////////////
	// Helpers

	function automatic kwic_pkg::kwic_chan_cfg_type chan_write(input logic [7:0] data);
		logic [7:0] v;
		v = data & `KWIC_CH_WMASK;
		return kwic_pkg::kwic_chan_cfg_type'(v);
	endfunction

	function automatic logic hit_addr(input logic [7:0] adr, input logic [7:0] ofs);
		return adr[7:2] == ofs[7:2];
	endfunction

	// Reserved bits read as zero whatever the register holds
	function automatic logic [7:0] chan_read(input kwic_pkg::kwic_chan_cfg_type cfg);
		logic [7:0] v;
		v = cfg;
		return v & `KWIC_CH_WMASK;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Bus handshake

	logic ack_q, ack_d;
	logic [31:0] rdat_q, rdat_d;
	logic bus_req;
	logic wr_fire;

	assign bus_req = req.cyc && req.stb;
	// Writes land on the edge where the master sees ack, not earlier
	assign wr_fire = bus_req && req.we && ack_q && req.sel[0];

	////////////////////////////////////////////////////////////////////////////
	// Address decode

	logic sel_ch6;
	logic sel_ch7;
	logic sel_status;
	logic sel_mask;
	logic sel_pins;
	logic [NCH-1:0] wr_ch;
	logic wr_status;
	logic wr_mask;
	kwic_pkg::kwic_chan_cfg_type wr_cfg;

	// Only address bits 7..2 are decoded, so byte offsets alias inside a word
	assign sel_ch6 = hit_addr(req.adr, `KWIC_OFS_CH6);
	assign sel_ch7 = hit_addr(req.adr, `KWIC_OFS_CH7);
	assign sel_status = hit_addr(req.adr, `KWIC_OFS_STATUS);
	assign sel_mask = hit_addr(req.adr, `KWIC_OFS_MASK);
	assign sel_pins = hit_addr(req.adr, `KWIC_OFS_PINS);
	// Write strobes; the pin view has none, it is read-only
	assign wr_ch[0] = wr_fire && sel_ch6;
	assign wr_ch[1] = wr_fire && sel_ch7;
	assign wr_status = wr_fire && sel_status;
	assign wr_mask = wr_fire && sel_mask;
	// Bits 3..1 are forced to zero so they always read back as zero
	assign wr_cfg = chan_write(req.dat[7:0]);

	////////////////////////////////////////////////////////////////////////////
	// Register state

	kwic_pkg::kwic_chan_cfg_type cfg_q [NCH];
	kwic_pkg::kwic_chan_cfg_type cfg_d [NCH];
	logic [NCH-1:0] status_q, status_d;
	logic [NCH-1:0] mask_q, mask_d;
	logic [NCH-1:0] hit;
	logic [NCH-1:0] level;
	logic [NCH-1:0] pu_on;
	logic [NCH-1:0] sample_en;
	logic [NCH-1:0] event_set;
	logic [NCH-1:0] status_clr;

	////////////////////////////////////////////////////////////////////////////
	// Channels

	for (genvar c = 0; c < NCH; c++) begin : g_ch
		kwic_pullup #(
			.PERIOD_CYC(PU_PERIOD_CYC),
			.ON_CYC(PU_ON_CYC)
		) u_pullup (
			.clk(clk),
			.sys_rst(sys_rst),
			.pullup_dyn(cfg_q[c].pullup_dyn),
			.pullup_on(pu_on[c]),
			.sample_en(sample_en[c])
		);

		kwic_detect u_detect (
			.clk(clk),
			.sys_rst(sys_rst),
			.key_pin(key_pin[c]),
			.sample_en(sample_en[c]),
			.trig(cfg_q[c].trig),
			.hit(hit[c]),
			.level(level[c])
		);
	end

	assign key_pullup_en = pu_on;

	////////////////////////////////////////////////////////////////////////////
	// Events

	// A disabled channel cannot post an event at all
	always_comb begin
		for (int c = 0; c < NCH; c++) begin
			event_set[c] = hit[c] && cfg_q[c].irq_en;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Channel control registers

	always_comb begin
		for (int c = 0; c < NCH; c++) begin
			cfg_d[c] = cfg_q[c];
			if (wr_ch[c]) begin
				cfg_d[c] = wr_cfg;
			end
		end
	end

	// Both channels come out of reset identical
	always_ff @(posedge clk) begin
		for (int c = 0; c < NCH; c++) begin
			if (sys_rst) begin
				cfg_q[c] <= kwic_pkg::kwic_chan_cfg_type'(`KWIC_CH_RESET);
			end else begin
				cfg_q[c] <= cfg_d[c];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Status

	always_comb begin
		status_clr = '0;
		if (wr_status) begin
			status_clr = req.dat[NCH-1:0];
		end
		// A new event in the clearing cycle survives the clear
		status_d = (status_q & ~status_clr) | event_set;
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			status_q <= '0;
		end else begin
			status_q <= status_d;
		end
	end

	assign key_wake_req = status_q;

	////////////////////////////////////////////////////////////////////////////
	// Mask

	always_comb begin
		mask_d = mask_q;
		if (wr_mask) begin
			mask_d = req.dat[NCH-1:0];
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			mask_q <= '0;
		end else begin
			mask_q <= mask_d;
		end
	end

	// Mask gates only the shared line; the per-channel requests stay visible
	assign irq = |(status_q & mask_q);

	////////////////////////////////////////////////////////////////////////////
	// Pin view

	logic [7:0] pins_view;

	// Levels are the detector's last samples, so a dynamic channel shows its last window
	always_comb begin
		pins_view = 8'h00;
		pins_view[NCH-1:0] = level;
		pins_view[`KWIC_PINS_PU_LSB +: NCH] = pu_on;
	end

	////////////////////////////////////////////////////////////////////////////
	// Read data select

	logic [31:0] rmux;

	// Unmapped addresses still ack, reading zero, so the bus never hangs
	always_comb begin
		rmux = 32'h0000_0000;
		if (sel_ch6) begin
			rmux[7:0] = chan_read(cfg_q[0]);
		end
		if (sel_ch7) begin
			rmux[7:0] = chan_read(cfg_q[1]);
		end
		if (sel_status) begin
			rmux[NCH-1:0] = status_q;
		end
		if (sel_mask) begin
			rmux[NCH-1:0] = mask_q;
		end
		if (sel_pins) begin
			rmux[7:0] = pins_view;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Ack

	// Ack drops after one cycle, so a master that holds its strobe re-arms it
	always_comb begin
		ack_d = bus_req && !ack_q;
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= ack_d;
		end
	end

	assign wb_ack_o = ack_q;

	////////////////////////////////////////////////////////////////////////////
	// Read data register

	// Data is captured with ack and then held until the next access
	always_comb begin
		rdat_d = rdat_q;
		if (ack_d) begin
			rdat_d = rmux;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			rdat_q <= 32'h0000_0000;
		end else begin
			rdat_q <= rdat_d;
		end
	end

	assign wb_dat_o = rdat_q;

endmodule // kwic_top

`default_nettype wire
